/* qsf_front.sv */
// Purpose: command front end of a quad serial flash, link side and user side
// Assumes: host drives chip select and serial clock; array read is combinational
// Notes: link logic runs on i_sclk and, apart from the program byte handoff, is cleared while chip select is high
//
// Operation
// - Quad mode moves opcode, address, data on four
// - Opcode 35h in single mode enters quad
// - Opcode F5h in quad mode leaves quad
// - 03h: three single-line address bytes, then data
// - 0Bh: address, dummy eight or four clocks
// - 3Bh: single address, eight dummy, two-line data
// - BBh: two-line address, four dummy, two-line data
// - EBh: four-line address, six dummy, four-line data
// - E7h: like EBh with four dummy clocks
// - 6Bh: single address, eight dummy, four-line data
// - 02h: address then page data, both modes
// - 38h: address, four-line data, single mode only
// - 20h with address erases 4K sector
// - 52h with address erases 32K block
// - D8h with address erases 64K block
// - Sample on rising edge, drive on falling
// - Write-class commands need byte-aligned select rise
// - Select rise ends read data at once
`timescale 1ns/1ps
`default_nettype none
`include "qsf_consts.svh"
module qsf_front (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   output logic [3:0] o_io,
   output logic [3:0] o_io_en_n,
   output logic [23:0] o_arr_addr,
   input wire logic [7:0] i_arr_data,
   output logic o_cmd_valid,
   output qsf_pkg::qsf_cmd_e o_cmd_kind,
   output logic [23:0] o_cmd_addr,
   output logic o_cmd_abort,
   output logic o_pgm_valid,
   output logic [7:0] o_pgm_data,
   output logic o_quad_mode
);

   // Opcode decode for the current command mode
   function automatic qsf_pkg::qsf_dec_s decode(input logic [7:0] op, input logic quad);
      qsf_pkg::qsf_dec_s d;
      d = '0;
      d.kind = qsf_pkg::CMD_NONE;
      d.aw = quad ? `QSF_LANES_4 : `QSF_LANES_1;
      d.dw = quad ? `QSF_LANES_4 : `QSF_LANES_1;
      d.dummy = `QSF_DUMMY_0;
      d.has_addr = 1'b1;
      case (op)
         `QSF_OP_READ: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_READ;
            d.rd = 1'b1;
         end
         `QSF_OP_FAST: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_FAST;
            d.rd = 1'b1;
            d.dummy = quad ? `QSF_DUMMY_4 : `QSF_DUMMY_8;
         end
         `QSF_OP_DUAL_OUT: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_DUAL_OUT;
            d.rd = 1'b1;
            d.dummy = `QSF_DUMMY_8;
            d.dw = `QSF_LANES_2;
         end
         `QSF_OP_TWO_IO: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_TWO_IO;
            d.rd = 1'b1;
            d.aw = `QSF_LANES_2;
            d.dummy = `QSF_DUMMY_4;
            d.dw = `QSF_LANES_2;
         end
         `QSF_OP_FOUR_IO, `QSF_OP_FOUR_IO_SHORT: begin
            d.ok = 1'b1;
            d.kind = (op == `QSF_OP_FOUR_IO) ? qsf_pkg::CMD_FOUR_IO : qsf_pkg::CMD_FOUR_IO_SHORT;
            d.rd = 1'b1;
            d.aw = `QSF_LANES_4;
            d.dummy = (op == `QSF_OP_FOUR_IO) ? `QSF_DUMMY_6 : `QSF_DUMMY_4;
            d.dw = `QSF_LANES_4;
         end
         `QSF_OP_FOUR_OUT: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_FOUR_OUT;
            d.rd = 1'b1;
            d.dummy = `QSF_DUMMY_8;
            d.dw = `QSF_LANES_4;
         end
         `QSF_OP_PAGE: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_PAGE;
            d.wr = 1'b1;
         end
         `QSF_OP_PAGE4: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_PAGE4;
            d.wr = 1'b1;
            d.dw = `QSF_LANES_4;
         end
         `QSF_OP_SECT: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_SECT;
         end
         `QSF_OP_HALF: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_HALF;
         end
         `QSF_OP_FULL: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_FULL;
         end
         `QSF_OP_CHIP_A, `QSF_OP_CHIP_B: begin
            d.ok = 1'b1;
            d.kind = qsf_pkg::CMD_CHIP;
            d.has_addr = 1'b0;
         end
         `QSF_OP_ENTER: begin
            d.ok = !quad;
            d.kind = qsf_pkg::CMD_ENTER;
            d.has_addr = 1'b0;
         end
         `QSF_OP_LEAVE: begin
            d.ok = quad;
            d.kind = qsf_pkg::CMD_LEAVE;
            d.has_addr = 1'b0;
         end
         default: begin
            d.ok = 1'b0;
         end
      endcase
      return d;
   endfunction : decode

   // Lane mask for a lane count: single line uses lane 0 in, lane 1 out
   function automatic logic [3:0] lane_sel(input logic [2:0] w, input logic outward);
      logic [3:0] m;
      m = 4'h1;
      if (w == `QSF_LANES_4) begin
         m = 4'hf;
      end else if (w == `QSF_LANES_2) begin
         m = 4'h3;
      end else if (outward) begin
         m = 4'h2;
      end
      return m;
   endfunction : lane_sel

   // Link-side state, rising edge of i_sclk
   qsf_pkg::qsf_state_e state_q, state_d;
   qsf_pkg::qsf_dec_s dec_q, dec_d;
   logic [3:0] bits_q, bits_d;
   logic [1:0] abytes_q, abytes_d;
   logic [3:0] dcnt_q, dcnt_d;
   logic [7:0] sh_q, sh_d;
   logic [23:0] addr_q, addr_d;
   logic pgm_tog_q, pgm_tog_d;
   logic [7:0] pgm_byte_q, pgm_byte_d;
   // Frame-end state, rising edge of i_cs_n
   logic quad_q;
   logic cmd_tog_q;
   logic abort_tog_q;
   qsf_pkg::qsf_cmd_e end_kind_q;
   logic [23:0] end_addr_q;
   // Output side, falling edge of i_sclk
   logic [3:0] io_q;
   logic [3:0] io_en_n_q;
   logic [7:0] obuf_q;
   logic [3:0] orem_q;
   logic started_q;
   logic [23:0] rd_addr_q;

   // Lane count and byte progress for the current phase
   wire logic [2:0] lane_w = (state_q == qsf_pkg::ST_OPC) ?
      (quad_q ? `QSF_LANES_4 : `QSF_LANES_1) :
      (state_q == qsf_pkg::ST_ADDR) ? dec_q.aw : dec_q.dw;
   wire logic [3:0] in_mask = lane_sel(lane_w, 1'b0);
   wire logic [7:0] sh_in = (lane_w == `QSF_LANES_4) ? {sh_q[3:0], i_io} :
      (lane_w == `QSF_LANES_2) ? {sh_q[5:0], i_io[1:0]} : {sh_q[6:0], i_io[0]};
   wire logic [3:0] bits_sum = bits_q + {1'b0, lane_w};
   wire logic byte_end = (bits_sum == `QSF_BYTE_BITS) && (in_mask != 4'h0);
   wire qsf_pkg::qsf_dec_s dec_new = decode(sh_in, quad_q);

   // Command sequencing on each rising clock
   always_comb begin
      state_d = state_q;
      dec_d = dec_q;
      bits_d = bits_q;
      abytes_d = abytes_q;
      dcnt_d = dcnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      pgm_tog_d = pgm_tog_q;
      pgm_byte_d = pgm_byte_q;
      case (state_q)
         qsf_pkg::ST_OPC: begin
            sh_d = sh_in;
            bits_d = byte_end ? 4'h0 : bits_sum;
            if (byte_end) begin
               dec_d = dec_new;
               abytes_d = 2'h0;
               if (!dec_new.ok) begin
                  state_d = qsf_pkg::ST_IGNORE;
               end else if (dec_new.has_addr) begin
                  state_d = qsf_pkg::ST_ADDR;
               end else begin
                  state_d = qsf_pkg::ST_DONE;
               end
            end
         end
         qsf_pkg::ST_ADDR: begin
            sh_d = sh_in;
            bits_d = byte_end ? 4'h0 : bits_sum;
            if (byte_end) begin
               addr_d = {addr_q[15:0], sh_in};
               abytes_d = abytes_q + 2'h1;
               if (abytes_q == `QSF_LAST_ADDR_BYTE) begin
                  dcnt_d = dec_q.dummy;
                  if (dec_q.rd && dec_q.dummy == `QSF_DUMMY_0) begin
                     state_d = qsf_pkg::ST_RDATA;
                  end else if (dec_q.rd) begin
                     state_d = qsf_pkg::ST_DUMMY;
                  end else if (dec_q.wr) begin
                     state_d = qsf_pkg::ST_WDATA;
                  end else begin
                     state_d = qsf_pkg::ST_DONE;
                  end
               end
            end
         end
         qsf_pkg::ST_DUMMY: begin
            dcnt_d = dcnt_q - 4'h1;
            if (dcnt_q == 4'h1) begin
               state_d = qsf_pkg::ST_RDATA;
            end
         end
         qsf_pkg::ST_WDATA: begin
            sh_d = sh_in;
            bits_d = byte_end ? 4'h0 : bits_sum;
            if (byte_end) begin
               pgm_byte_d = sh_in;
               pgm_tog_d = ~pgm_tog_q;
            end
         end
         qsf_pkg::ST_DONE: begin
            state_d = qsf_pkg::ST_IGNORE;
         end
         default: begin
            state_d = state_q;
         end
      endcase
   end

   // sample on rising edge; cleared while deselected
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         state_q <= qsf_pkg::ST_OPC;
         dec_q <= '0;
         bits_q <= 4'h0;
         abytes_q <= 2'h0;
         dcnt_q <= 4'h0;
         sh_q <= 8'h00;
         addr_q <= 24'h000000;
      end else begin
         state_q <= state_d;
         dec_q <= dec_d;
         bits_q <= bits_d;
         abytes_q <= abytes_d;
         dcnt_q <= dcnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
      end
   end

   // Program byte handoff, kept across frames so the toggle stays honest
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         pgm_tog_q <= 1'b0;
         pgm_byte_q <= 8'h00;
      end else begin
         pgm_tog_q <= pgm_tog_d;
         pgm_byte_q <= pgm_byte_d;
      end
   end

   // Write-class frame outcome at the rising select edge
   wire logic wr_class = dec_q.ok && !dec_q.rd && (state_q != qsf_pkg::ST_OPC);
   wire logic end_ok = wr_class && ((state_q == qsf_pkg::ST_DONE) ||
      ((state_q == qsf_pkg::ST_WDATA) && (bits_q == 4'h0)));
   wire logic end_bad = wr_class && !end_ok;
   wire logic [23:0] end_mask = (dec_q.kind == qsf_pkg::CMD_SECT) ? `QSF_MASK_SECT :
      (dec_q.kind == qsf_pkg::CMD_HALF) ? `QSF_MASK_HALF :
      (dec_q.kind == qsf_pkg::CMD_FULL) ? `QSF_MASK_FULL : `QSF_MASK_NONE;

   // Commit or reject on select rise; link state is read before it clears
   always_ff @(posedge i_cs_n or posedge i_rst) begin
      if (i_rst) begin
         quad_q <= 1'b0;
         cmd_tog_q <= 1'b0;
         abort_tog_q <= 1'b0;
         end_kind_q <= qsf_pkg::CMD_NONE;
         end_addr_q <= 24'h000000;
      end else if (end_ok) begin
         cmd_tog_q <= ~cmd_tog_q;
         end_kind_q <= dec_q.kind;
         end_addr_q <= addr_q & end_mask;
         if (dec_q.kind == qsf_pkg::CMD_ENTER) begin
            quad_q <= 1'b1;
         end
         if (dec_q.kind == qsf_pkg::CMD_LEAVE) begin
            quad_q <= 1'b0;
         end
      end else if (end_bad) begin
         abort_tog_q <= ~abort_tog_q;
      end
   end

   // Read data lanes for the falling edge
   wire logic ld_byte = (orem_q == 4'h0);
   wire logic [7:0] cur_byte = ld_byte ? i_arr_data : obuf_q;
   wire logic [3:0] out_mask = lane_sel(dec_q.dw, 1'b1);
   wire logic [3:0] io_next = (dec_q.dw == `QSF_LANES_4) ? cur_byte[7:4] :
      (dec_q.dw == `QSF_LANES_2) ? {2'b00, cur_byte[7:6]} : {2'b00, cur_byte[7], 1'b0};
   wire logic [7:0] obuf_next = (dec_q.dw == `QSF_LANES_4) ? {cur_byte[3:0], 4'h0} :
      (dec_q.dw == `QSF_LANES_2) ? {cur_byte[5:0], 2'b00} : {cur_byte[6:0], 1'b0};
   wire logic [3:0] orem_next = (ld_byte ? `QSF_BYTE_BITS : orem_q) - {1'b0, dec_q.dw};

   // Array address: captured address first, then the running one
   assign o_arr_addr = started_q ? rd_addr_q : addr_q;

   // drive on falling edge; select rise floats lanes at once
   always_ff @(negedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         io_q <= 4'h0;
         io_en_n_q <= 4'hf;
         obuf_q <= 8'h00;
         orem_q <= 4'h0;
         started_q <= 1'b0;
         rd_addr_q <= 24'h000000;
      end else if (state_q == qsf_pkg::ST_RDATA) begin
         io_q <= io_next;
         io_en_n_q <= ~out_mask;
         obuf_q <= obuf_next;
         orem_q <= orem_next;
         if (ld_byte) begin
            started_q <= 1'b1;
            rd_addr_q <= o_arr_addr + 24'h000001;
         end
      end
   end

   assign o_io = io_q;
   assign o_io_en_n = io_en_n_q;

   // Crossings into the i_clk domain
   logic cmd_pulse;
   logic abort_pulse;
   logic pgm_pulse;

   qsf_tog_pulse u_cmd_x (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tog(cmd_tog_q),
      .o_pulse(cmd_pulse)
   );

   qsf_tog_pulse u_abort_x (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tog(abort_tog_q),
      .o_pulse(abort_pulse)
   );

   qsf_tog_pulse u_pgm_x (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tog(pgm_tog_q),
      .o_pulse(pgm_pulse)
   );

   qsf_sync u_quad_x (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(quad_q),
      .o_q(o_quad_mode)
   );

   // User-side events; words change with their toggle and are stable by its pulse
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_cmd_valid <= 1'b0;
         o_cmd_kind <= qsf_pkg::CMD_NONE;
         o_cmd_addr <= 24'h000000;
         o_cmd_abort <= 1'b0;
         o_pgm_valid <= 1'b0;
         o_pgm_data <= 8'h00;
      end else begin
         o_cmd_valid <= cmd_pulse;
         o_cmd_abort <= abort_pulse;
         o_pgm_valid <= pgm_pulse;
         if (cmd_pulse) begin
            o_cmd_kind <= end_kind_q;
            o_cmd_addr <= end_addr_q;
         end
         if (pgm_pulse) begin
            o_pgm_data <= pgm_byte_q;
         end
      end
   end

endmodule : qsf_front
`default_nettype wire

/* qsf_consts.svh */
// Purpose: constants of the quad serial flash command front end
// Assumes: included by its bare name
// Notes: definitions only
`ifndef QSF_CONSTS_SVH
`define QSF_CONSTS_SVH

// Opcodes
`define QSF_OP_READ 8'h03
`define QSF_OP_FAST 8'h0b
`define QSF_OP_DUAL_OUT 8'h3b
`define QSF_OP_TWO_IO 8'hbb
`define QSF_OP_FOUR_IO 8'heb
`define QSF_OP_FOUR_IO_SHORT 8'he7
`define QSF_OP_FOUR_OUT 8'h6b
`define QSF_OP_PAGE 8'h02
`define QSF_OP_PAGE4 8'h38
`define QSF_OP_SECT 8'h20
`define QSF_OP_HALF 8'h52
`define QSF_OP_FULL 8'hd8
`define QSF_OP_CHIP_A 8'h60
`define QSF_OP_CHIP_B 8'hc7
`define QSF_OP_ENTER 8'h35
`define QSF_OP_LEAVE 8'hf5

// Lane counts per clock
`define QSF_LANES_1 3'h1
`define QSF_LANES_2 3'h2
`define QSF_LANES_4 3'h4

// Dummy clock counts
`define QSF_DUMMY_0 4'h0
`define QSF_DUMMY_4 4'h4
`define QSF_DUMMY_6 4'h6
`define QSF_DUMMY_8 4'h8

// Bits per byte and address bytes
`define QSF_BYTE_BITS 4'h8
`define QSF_LAST_ADDR_BYTE 2'h2

// Erase unit alignment masks
`define QSF_MASK_SECT 24'hfff000
`define QSF_MASK_HALF 24'hff8000
`define QSF_MASK_FULL 24'hff0000
`define QSF_MASK_NONE 24'hffffff

`endif

/* qsf_pkg.sv */
// Purpose: types of the quad serial flash command front end
// Assumes: nothing
// Notes: numbers live in qsf_consts.svh
package qsf_pkg;

   // Link states, one-hot
   typedef enum logic [6:0] {
      ST_OPC = 7'h01,
      ST_ADDR = 7'h02,
      ST_DUMMY = 7'h04,
      ST_RDATA = 7'h08,
      ST_WDATA = 7'h10,
      ST_DONE = 7'h20,
      ST_IGNORE = 7'h40
   } qsf_state_e;

   // Command kinds reported to the user side
   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_READ = 4'h1,
      CMD_FAST = 4'h2,
      CMD_DUAL_OUT = 4'h3,
      CMD_TWO_IO = 4'h4,
      CMD_FOUR_IO = 4'h5,
      CMD_FOUR_IO_SHORT = 4'h6,
      CMD_FOUR_OUT = 4'h7,
      CMD_PAGE = 4'h8,
      CMD_PAGE4 = 4'h9,
      CMD_SECT = 4'ha,
      CMD_HALF = 4'hb,
      CMD_FULL = 4'hc,
      CMD_CHIP = 4'hd,
      CMD_ENTER = 4'he,
      CMD_LEAVE = 4'hf
   } qsf_cmd_e;

   // Decoded opcode
   typedef struct packed {
      logic ok;
      qsf_cmd_e kind;
      logic [2:0] aw;
      logic [3:0] dummy;
      logic [2:0] dw;
      logic has_addr;
      logic rd;
      logic wr;
   } qsf_dec_s;

endpackage : qsf_pkg

/* qsf_sync.sv */
// Purpose: two-flop synchroniser for a level
// Assumes: i_d is steady for several i_clk cycles
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module qsf_sync (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_d,
   output logic o_q
);
   logic meta_q;

   // Two stages
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= 1'b0;
         o_q <= 1'b0;
      end else begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule : qsf_sync
`default_nettype wire

/* qsf_tog_pulse.sv */
// Purpose: turns a toggle from another clock into a one-cycle pulse
// Assumes: toggles are spaced by at least four i_clk cycles
// Notes: pulse comes from a flop
`timescale 1ns/1ps
`default_nettype none
module qsf_tog_pulse (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tog,
   output logic o_pulse
);
   logic tog_s;
   logic tog_last_q;

   qsf_sync u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(i_tog),
      .o_q(tog_s)
   );

   // Edge of the synchronised toggle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tog_last_q <= 1'b0;
         o_pulse <= 1'b0;
      end else begin
         tog_last_q <= tog_s;
         o_pulse <= tog_s ^ tog_last_q;
      end
   end
endmodule : qsf_tog_pulse
`default_nettype wire

/* qsf_front_checker.sv */
// Purpose: concurrent checks on the ports of the flash command front end
// Assumes: bound to every qsf_front instance
// Notes: link checks are disabled while chip select is high
`timescale 1ns/1ps
`default_nettype none
module qsf_front_checker (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic [3:0] o_io,
   input wire logic [3:0] o_io_en_n,
   input wire logic o_cmd_valid,
   input wire qsf_pkg::qsf_cmd_e o_cmd_kind,
   input wire logic [23:0] o_cmd_addr,
   input wire logic o_cmd_abort,
   input wire logic o_pgm_valid,
   input wire logic o_quad_mode
);
   // Lanes float while the device is not selected
   property p_float;
      @(posedge i_clk) disable iff (i_rst) i_cs_n |-> o_io_en_n == 4'hf && o_io == 4'h0;
   endproperty
   a_float: assert property (p_float) else $error("lanes driven while deselected");
   // Only single, two-lane or four-lane drive patterns
   property p_lanes;
      @(posedge i_sclk) disable iff (i_cs_n) o_io_en_n inside {4'hf, 4'hd, 4'hc, 4'h0};
   endproperty
   a_lanes: assert property (p_lanes) else $error("odd lane enable pattern");
   // Quad mode data always uses four lanes
   property p_quad_en;
      @(posedge i_sclk) disable iff (i_cs_n)
         (o_quad_mode && o_io_en_n != 4'hf) |-> o_io_en_n == 4'h0;
   endproperty
   a_quad_en: assert property (p_quad_en) else $error("quad read not on four lanes");
   // Mode changes only between frames
   property p_mode_steady;
      @(posedge i_clk) disable iff (i_rst) $changed(o_quad_mode) |-> i_cs_n;
   endproperty
   a_mode_steady: assert property (p_mode_steady) else $error("mode changed in frame");
   // Commits happen only after select rise
   property p_commit_cs;
      @(posedge i_clk) disable iff (i_rst) o_cmd_valid |-> i_cs_n && !o_cmd_abort;
   endproperty
   a_commit_cs: assert property (p_commit_cs) else $error("commit inside frame");
   // Commit and abort are single pulses
   property p_pulse;
      @(posedge i_clk) disable iff (i_rst)
         (o_cmd_valid || o_cmd_abort) |=> !o_cmd_valid && !o_cmd_abort;
   endproperty
   a_pulse: assert property (p_pulse) else $error("commit pulse too long");
   // Program byte strobe is one cycle
   property p_pgm;
      @(posedge i_clk) disable iff (i_rst) o_pgm_valid |=> !o_pgm_valid;
   endproperty
   a_pgm: assert property (p_pgm) else $error("program strobe too long");
   // Outputs cleared one edge into reset
   property p_reset;
      @(posedge i_clk) i_rst |=> !o_cmd_valid && !o_pgm_valid && o_cmd_kind == qsf_pkg::CMD_NONE;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   // Erase addresses aligned to their unit
   property p_sect;
      @(posedge i_clk) disable iff (i_rst)
         o_cmd_valid && o_cmd_kind == qsf_pkg::CMD_SECT |-> o_cmd_addr[11:0] == 12'h000;
   endproperty
   a_sect: assert property (p_sect) else $error("sector address not aligned");
   property p_half;
      @(posedge i_clk) disable iff (i_rst)
         o_cmd_valid && o_cmd_kind == qsf_pkg::CMD_HALF |-> o_cmd_addr[14:0] == 15'h0000;
   endproperty
   a_half: assert property (p_half) else $error("half block not aligned");
   property p_full;
      @(posedge i_clk) disable iff (i_rst)
         o_cmd_valid && o_cmd_kind == qsf_pkg::CMD_FULL |-> o_cmd_addr[15:0] == 16'h0000;
   endproperty
   a_full: assert property (p_full) else $error("full block not aligned");
   c_cmd: cover property (@(posedge i_clk) o_cmd_valid);
   c_abort: cover property (@(posedge i_clk) o_cmd_abort);
   c_pgm: cover property (@(posedge i_clk) o_pgm_valid);
   c_quad: cover property (@(posedge i_sclk) o_io_en_n == 4'h0);
endmodule : qsf_front_checker
bind qsf_front qsf_front_checker qsf_front_checker_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_io(o_io), .o_io_en_n(o_io_en_n),
   .o_cmd_valid(o_cmd_valid), .o_cmd_kind(o_cmd_kind), .o_cmd_addr(o_cmd_addr),
   .o_cmd_abort(o_cmd_abort), .o_pgm_valid(o_pgm_valid), .o_quad_mode(o_quad_mode));
`default_nettype wire

/* qsf_host.sv */
// Purpose: behavioural host serial controller facing the front end
// Assumes: mode 0, clock low and still outside frames
// Notes: lanes left to the device show an inverting pattern
`timescale 1ns/1ps
`default_nettype none
module qsf_host (
   output logic o_sclk,
   output logic o_cs_n,
   output logic [3:0] o_io,
   input wire logic [3:0] i_io
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h0;
   end
   // drive in low phase, msb first
   task automatic put(input logic [31:0] v, input int nb, input int ln);
      for (int i = 0; i < nb / ln; i++) begin
         o_io = (ln == 1) ? {3'h0, v[31]} : (ln == 2) ? {2'h0, v[31:30]} : v[31:28];
         v = v << ln;
         #16 o_sclk = 1'b1;
         #16 o_sclk = 1'b0;
      end
   endtask : put
   // sample device lanes at rising edge
   task automatic get(input int ln, output logic [7:0] b);
      for (int i = 0; i < 8 / ln; i++) begin
         o_io = ~o_io;
         #16 o_sclk = 1'b1;
         b = (ln == 1) ? {b[6:0], i_io[1]} : (ln == 2) ? {b[5:0], i_io[1:0]} : {b[3:0], i_io};
         #16 o_sclk = 1'b0;
      end
   endtask : get
   // select edges on byte ends, long gap
   task automatic sel(input logic lvl);
      #8.3 o_cs_n = lvl;
      if (lvl) begin
         o_io = ~o_io;
         #120;
      end
   endtask : sel
endmodule : qsf_host
`default_nettype wire

/* quad_serial_flash_command_front_end_tb.sv */
// Purpose: self-checking bench for the flash command front end
// Assumes: array data is a fixed function of the address
// Notes: queues collect commits and program bytes for comparison
`timescale 1ns/1ps
`default_nettype none
`include "qsf_consts.svh"
module quad_serial_flash_command_front_end_tb;
   logic clk = 1'b0;
   logic rst;
   logic sclk, cs_n, cmd_v, abort, pgm_v, quad;
   logic [3:0] h_io, d_io, en_n;
   wire logic [3:0] io_w;
   logic [23:0] arr_addr, caddr, last_a;
   wire logic [7:0] arr_data;
   logic [7:0] pdata;
   qsf_pkg::qsf_cmd_e kind;
   logic [23:0] lf = 24'h000034;
   logic [23:0] q_kind[$], q_addr[$];
   logic [7:0] q_pgm[$], q_exp[$];
   int n_fail = 0;
   int n_compared = 0;
   int n_abort = 0;
   initial begin
      #0.3;
      forever #5 clk = ~clk;
   end
   // Wire level from both parties, array as address function
   assign io_w = (en_n & h_io) | (~en_n & d_io);
   assign arr_data = arr_addr[7:0] ^ arr_addr[15:8];
   qsf_host qsf_host_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(h_io), .i_io(io_w));
   qsf_front qsf_front_inst (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_io(io_w), .o_io(d_io), .o_io_en_n(en_n), .o_arr_addr(arr_addr),
      .i_arr_data(arr_data), .o_cmd_valid(cmd_v), .o_cmd_kind(kind), .o_cmd_addr(caddr),
      .o_cmd_abort(abort), .o_pgm_valid(pgm_v), .o_pgm_data(pdata), .o_quad_mode(quad));
   // Collect user-side events
   always @(posedge clk) begin
      if (cmd_v) begin
         q_kind.push_back(kind);
         q_addr.push_back(caddr);
      end
      if (pgm_v) q_pgm.push_back(pdata);
      if (abort) n_abort++;
   end
   function automatic logic [23:0] rnd();
      lf = {lf[22:0], lf[23] ^ lf[22] ^ lf[21] ^ lf[16]};
      return lf;
   endfunction : rnd
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : check
   task automatic wrap_up();
      if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // One frame: opcode, address, dummy, reads, writes, extra clocks
   task automatic run(input logic [7:0] op, input int ol, input int al, input int dm,
      input int nrd, input int dl, input int nwr, input int wl, input int xc);
      logic [23:0] ea;
      logic [7:0] b;
      last_a = rnd();
      qsf_host_inst.sel(1'b0);
      qsf_host_inst.put({op, 24'h0}, 8, ol);
      if (al > 0) qsf_host_inst.put({last_a, 8'h0}, 24, al);
      if (dm > 0) qsf_host_inst.put(32'h0, dm, 1);
      for (int i = 0; i < nrd; i++) begin
         qsf_host_inst.get(dl, b);
         ea = last_a + i[23:0];
         check("rd_data", b, ea[7:0] ^ ea[15:8]);
      end
      if (nrd < 0) begin
         qsf_host_inst.get(dl, b);
         check("refused_en", en_n, 4'hf);
      end
      for (int i = 0; i < nwr; i++) begin
         b = 8'(rnd());
         q_exp.push_back(b);
         qsf_host_inst.put({b, 24'h0}, 8, wl);
      end
      if (xc > 0) qsf_host_inst.put(32'h0, xc, 1);
      qsf_host_inst.sel(1'b1);
   endtask : run
   // Bounded wait for a commit, then program bytes
   task automatic exp_cmd(input qsf_pkg::qsf_cmd_e k, input logic [23:0] ea);
      for (int i = 0; i < 50 && q_kind.size() == 0; i++) @(posedge clk);
      if (q_kind.size() == 0) begin
         check("cmd_wait", 32'h0, 32'h1);
         wrap_up();
      end else begin
         check("cmd_kind", q_kind.pop_front(), k);
         check("cmd_addr", q_addr.pop_front(), ea);
         check("pgm_n", q_pgm.size(), q_exp.size());
         while (q_exp.size() > 0 && q_pgm.size() > 0)
            check("pgm", q_pgm.pop_front(), q_exp.pop_front());
         q_exp.delete();
         q_pgm.delete();
      end
   endtask : exp_cmd
   logic [7:0] rop[7] = '{8'h03, 8'h0b, 8'h3b, 8'hbb, 8'heb, 8'he7, 8'h6b};
   int ral[7] = '{1, 1, 1, 2, 4, 4, 1};
   int rdm[7] = '{0, 8, 8, 4, 6, 4, 8};
   int rdl[7] = '{1, 1, 2, 2, 4, 4, 4};
   logic [7:0] eop[5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
   qsf_pkg::qsf_cmd_e ek[5] = '{qsf_pkg::CMD_SECT, qsf_pkg::CMD_HALF, qsf_pkg::CMD_FULL,
      qsf_pkg::CMD_CHIP, qsf_pkg::CMD_CHIP};
   logic [23:0] em[5] = '{24'hfff000, 24'hff8000, 24'hff0000, 24'h0, 24'h0};
   initial begin
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("quad_rst", quad, 1'b0);
      for (int i = 0; i < 7; i++) run(rop[i], 1, ral[i], rdm[i], 2, rdl[i], 0, 1, 0);
      for (int i = 0; i < 5; i++) begin
         run(eop[i], 1, (i < 3) ? 1 : 0, 0, 0, 1, 0, 1, 0);
         exp_cmd(ek[i], last_a & em[i]);
      end
      run(`QSF_OP_PAGE, 1, 1, 0, 0, 1, 2, 1, 0);
      exp_cmd(qsf_pkg::CMD_PAGE, last_a);
      run(`QSF_OP_PAGE4, 1, 1, 0, 0, 1, 2, 4, 0);
      exp_cmd(qsf_pkg::CMD_PAGE4, last_a);
      run(`QSF_OP_SECT, 1, 1, 0, 0, 1, 0, 1, 3);
      check("abort_n", n_abort, 1);
      check("no_cmd", q_kind.size(), 0);
      run(`QSF_OP_ENTER, 1, 0, 0, 0, 1, 0, 1, 0);
      check("quad_on", quad, 1'b1);
      exp_cmd(qsf_pkg::CMD_ENTER, 24'h0);
      run(`QSF_OP_FAST, 4, 4, 4, 2, 4, 0, 1, 0);
      run(`QSF_OP_FOUR_IO, 4, 4, 6, 1, 4, 0, 1, 0);
      run(`QSF_OP_SECT, 4, 4, 0, 0, 1, 0, 1, 0);
      exp_cmd(qsf_pkg::CMD_SECT, last_a & 24'hfff000);
      run(`QSF_OP_READ, 4, 4, 0, -1, 4, 0, 1, 0);
      run(`QSF_OP_LEAVE, 4, 0, 0, 0, 1, 0, 1, 0);
      check("quad_off", quad, 1'b0);
      exp_cmd(qsf_pkg::CMD_LEAVE, 24'h0);
      run(`QSF_OP_READ, 1, 1, 0, 1, 1, 0, 1, 0);
      run(`QSF_OP_ENTER, 1, 0, 0, 0, 1, 0, 1, 0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check("quad_rst2", quad, 1'b0);
      wrap_up();
   end
endmodule : quad_serial_flash_command_front_end_tb
`default_nettype wire
